// *** include/msfh_params.svh ***
`ifndef MSFH_PARAMS_SVH
`define MSFH_PARAMS_SVH
`define MSFH_FC_READ_REGS 8'h03
`define MSFH_FC_WRITE_COIL 8'h05
`define MSFH_FC_WRITE_REG 8'h06
`define MSFH_FC_LOOPBACK 8'h08
`define MSFH_EXC_FLAG 8'h80
`define MSFH_EXC_NONE 8'h00
`define MSFH_EXC_FUNC 8'h01
`define MSFH_EXC_ADDR 8'h02
`define MSFH_EXC_DATA 8'h03
`define MSFH_EXC_RO 8'h22
`define MSFH_BCAST_ADDR 8'h00
`define MSFH_QUERY_LEN 4'h8
`define MSFH_CRC_COVER 4'h6
`define MSFH_MAX_REGS 16'h0030
`define MSFH_NO_REGS 16'h0000
`define MSFH_ONE_REG 16'h0001
`define MSFH_POS_WORDS 16'h0002
`define MSFH_REG_POS_LO 16'h0026
`define MSFH_REG_POS_HI 16'h0027
`define MSFH_REG_CTRL_MODE 16'h0064
`define MSFH_COIL_ENERGISE 16'h0000
`define MSFH_COIL_ON 16'hFF00
`define MSFH_COIL_OFF 16'h0000
`define MSFH_SUB_ECHO 16'h0000
`define MSFH_CRC_INIT 16'hFFFF
`define MSFH_CRC_POLY 16'hA001
`define MSFH_CTRL_MODE_RST 16'h0000
`define MSFH_EXC_LEN 8'h03
`define MSFH_ECHO_LEN 8'h06
`define MSFH_READ_HDR 8'h03
`endif

// *** include/msfh_pkg.sv ***
package msfh_pkg;
  typedef enum logic [1:0] {S_RX, S_CHECK, S_SEND} msfh_state_t;
  typedef enum logic [1:0] {R_ECHO, R_READ, R_EXC} msfh_resp_t;
endpackage

// *** verilog/msfh_crc16.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "msfh_params.svh"
module msfh_crc16 (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  import msfh_pkg::*;
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [15:0] c;

  always_comb begin
    c = crc_q ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `MSFH_CRC_POLY) : (c >> 1);
    end
    if (init) begin
      crc_d = `MSFH_CRC_INIT;
    end else if (en) begin
      crc_d = c;
    end else begin
      crc_d = crc_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      crc_q <= `MSFH_CRC_INIT;
    end else if (ce) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule
`default_nettype wire

// *** verilog/msfh_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "msfh_params.svh"
module msfh_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] own_addr,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_frame_end,
  input wire logic rx_char_err,
  input wire logic rx_gap_err,
  input wire logic tx_ready,
  input wire logic [31:0] position_in,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic drive_energise,
  output logic [15:0] control_mode_param
);
  import msfh_pkg::*;

  msfh_state_t state_q, state_d;
  msfh_resp_t resp_q, resp_d;
  logic [3:0] cnt_q, cnt_d;
  logic bad_q, bad_d;
  logic [7:0] buf_q [8];
  logic [7:0] buf_d [8];
  logic [7:0] exc_q, exc_d;
  logic [7:0] plen_q, plen_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic tx_valid_q, tx_valid_d;
  logic [31:0] pos_q, pos_d;
  logic coil_q, coil_d;
  logic [15:0] mode_q, mode_d;

  logic crc_init;
  logic crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_val;

  logic [7:0] fc;
  logic [15:0] fa;
  logic [15:0] fd;
  logic bcast;
  logic accept;
  logic rd_map;
  msfh_resp_t dec_resp;
  logic [7:0] dec_exc;
  logic [7:0] dec_plen;
  logic dec_coil;
  logic dec_write;
  logic [7:0] rd_off;
  logic [15:0] rd_addr;
  logic [15:0] rd_word;
  logic [7:0] txb;

  msfh_crc16 u_crc (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .init(crc_init),
    .en(crc_en),
    .data(crc_data),
    .crc(crc_val)
  );

  function automatic logic [15:0] reg_val(input logic [15:0] a,
                                          input logic [31:0] pos,
                                          input logic [15:0] mode);
    case (a)
      `MSFH_REG_POS_LO: reg_val = pos[15:0];
      `MSFH_REG_POS_HI: reg_val = pos[31:16];
      `MSFH_REG_CTRL_MODE: reg_val = mode;
      default: reg_val = 16'h0000;
    endcase
  endfunction

  // Query fields, laid out the same for all four functions
  assign fc = buf_q[1];
  assign fa = {buf_q[2], buf_q[3]};
  assign fd = {buf_q[4], buf_q[5]};
  assign bcast = buf_q[0] == `MSFH_BCAST_ADDR;
  // Stored CRC arrives high byte first
  assign accept = (crc_val == {buf_q[6], buf_q[7]}) &&
                  (bcast || buf_q[0] == own_addr);
  // Only the mapped words may be covered by a read
  assign rd_map = (fa == `MSFH_REG_POS_LO && fd <= `MSFH_POS_WORDS) ||
                  (fa == `MSFH_REG_POS_HI && fd == `MSFH_ONE_REG) ||
                  (fa == `MSFH_REG_CTRL_MODE && fd == `MSFH_ONE_REG);

  always_comb begin
    dec_resp = R_ECHO;
    dec_exc = `MSFH_EXC_NONE;
    dec_plen = `MSFH_ECHO_LEN;
    dec_coil = 1'b0;
    dec_write = 1'b0;
    case (fc)
      `MSFH_FC_READ_REGS: begin
        if (fd == `MSFH_NO_REGS || fd > `MSFH_MAX_REGS) begin
          dec_exc = `MSFH_EXC_DATA;
        end else if (!rd_map) begin
          dec_exc = `MSFH_EXC_ADDR;
        end else begin
          dec_resp = R_READ;
          dec_plen = `MSFH_READ_HDR + {fd[6:0], 1'b0};
        end
      end
      `MSFH_FC_WRITE_COIL: begin
        if (fa != `MSFH_COIL_ENERGISE) begin
          dec_exc = `MSFH_EXC_ADDR;
        end else if (fd != `MSFH_COIL_ON && fd != `MSFH_COIL_OFF) begin
          dec_exc = `MSFH_EXC_DATA;
        end else begin
          dec_coil = 1'b1;
        end
      end
      `MSFH_FC_WRITE_REG: begin
        if (fa == `MSFH_REG_CTRL_MODE) begin
          dec_write = 1'b1;
        end else if (fa == `MSFH_REG_POS_LO || fa == `MSFH_REG_POS_HI) begin
          dec_exc = `MSFH_EXC_RO;
        end else begin
          dec_exc = `MSFH_EXC_ADDR;
        end
      end
      `MSFH_FC_LOOPBACK: begin
        if (fa != `MSFH_SUB_ECHO) begin
          dec_exc = `MSFH_EXC_ADDR;
        end
      end
      default: dec_exc = `MSFH_EXC_FUNC;
    endcase
    if (dec_exc != `MSFH_EXC_NONE) begin
      dec_resp = R_EXC;
      dec_plen = `MSFH_EXC_LEN;
      dec_coil = 1'b0;
      dec_write = 1'b0;
    end
  end

  // Outgoing byte for the current index
  assign rd_off = idx_q - `MSFH_READ_HDR;
  assign rd_addr = fa + {9'h000, rd_off[7:1]};
  assign rd_word = reg_val(rd_addr, pos_q, mode_q);

  always_comb begin
    if (idx_q == plen_q) begin
      txb = crc_val[15:8];
    end else if (idx_q > plen_q) begin
      txb = crc_val[7:0];
    end else begin
      case (resp_q)
        R_EXC: begin
          if (idx_q == 8'h00) begin
            txb = buf_q[0];
          end else if (idx_q == 8'h01) begin
            txb = buf_q[1] | `MSFH_EXC_FLAG;
          end else begin
            txb = exc_q;
          end
        end
        R_READ: begin
          if (idx_q < 8'h02) begin
            txb = buf_q[idx_q[2:0]];
          end else if (idx_q == 8'h02) begin
            txb = plen_q - `MSFH_READ_HDR;
          end else begin
            txb = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
          end
        end
        default: txb = buf_q[idx_q[2:0]];
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    resp_d = resp_q;
    cnt_d = cnt_q;
    bad_d = bad_q;
    buf_d = buf_q;
    exc_d = exc_q;
    plen_d = plen_q;
    idx_d = idx_q;
    tx_byte_d = tx_byte_q;
    tx_valid_d = tx_valid_q;
    pos_d = pos_q;
    coil_d = coil_q;
    mode_d = mode_q;
    crc_init = 1'b0;
    crc_en = 1'b0;
    crc_data = rx_byte;
    case (state_q)
      S_RX: begin
        if (rx_valid) begin
          if (cnt_q < `MSFH_QUERY_LEN) begin
            buf_d[cnt_q[2:0]] = rx_byte;
          end
          if (cnt_q < `MSFH_CRC_COVER) begin
            crc_en = 1'b1;
          end
          // Saturate one past a full query to catch long frames
          if (cnt_q <= `MSFH_QUERY_LEN) begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        if (rx_char_err || rx_gap_err) begin
          bad_d = 1'b1;
        end
        if (rx_frame_end) begin
          cnt_d = 4'h0;
          bad_d = 1'b0;
          if (cnt_q == `MSFH_QUERY_LEN && !bad_q &&
              !rx_char_err && !rx_gap_err) begin
            state_d = S_CHECK;
          end else begin
            crc_init = 1'b1;
          end
        end
      end
      S_CHECK: begin
        crc_init = 1'b1;
        state_d = S_RX;
        // Snapshot keeps both halves of a double word coherent
        pos_d = position_in;
        if (accept) begin
          if (dec_coil) begin
            coil_d = fd == `MSFH_COIL_ON;
          end
          if (dec_write) begin
            mode_d = fd;
          end
          if (!bcast) begin
            state_d = S_SEND;
            resp_d = dec_resp;
            exc_d = dec_exc;
            plen_d = dec_plen;
            idx_d = 8'h00;
          end
        end
      end
      S_SEND: begin
        if (!tx_valid_q) begin
          tx_byte_d = txb;
          tx_valid_d = 1'b1;
          if (idx_q < plen_q) begin
            crc_en = 1'b1;
            crc_data = txb;
          end
        end else if (tx_ready) begin
          tx_valid_d = 1'b0;
          idx_d = idx_q + 8'h01;
          if (idx_q > plen_q) begin
            state_d = S_RX;
            crc_init = 1'b1;
          end
        end
      end
      default: state_d = S_RX;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= S_RX;
      resp_q <= R_ECHO;
      cnt_q <= 4'h0;
      bad_q <= 1'b0;
      buf_q <= '{default: 8'h00};
      exc_q <= `MSFH_EXC_NONE;
      plen_q <= `MSFH_ECHO_LEN;
      idx_q <= 8'h00;
      tx_byte_q <= 8'h00;
      tx_valid_q <= 1'b0;
      pos_q <= 32'h0000_0000;
      coil_q <= 1'b0;
      mode_q <= `MSFH_CTRL_MODE_RST;
    end else if (ce) begin
      state_q <= state_d;
      resp_q <= resp_d;
      cnt_q <= cnt_d;
      bad_q <= bad_d;
      buf_q <= buf_d;
      exc_q <= exc_d;
      plen_q <= plen_d;
      idx_q <= idx_d;
      tx_byte_q <= tx_byte_d;
      tx_valid_q <= tx_valid_d;
      pos_q <= pos_d;
      coil_q <= coil_d;
      mode_q <= mode_d;
    end
  end

  assign tx_byte = tx_byte_q;
  assign tx_valid = tx_valid_q;
  assign drive_energise = coil_q;
  assign control_mode_param = mode_q;
endmodule
`default_nettype wire

// *** verif/msfh_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module msfh_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] own_addr,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_frame_end,
  input wire logic rx_char_err,
  input wire logic rx_gap_err,
  input wire logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic drive_energise,
  input wire logic [15:0] control_mode_param
);
  logic [63:0] sh_q;
  logic [7:0] n_q;
  logic err_q;
  logic bad;
  assign bad = err_q || rx_char_err || rx_gap_err;
  // Last query held whole; byte 0 ends up on top
  always_ff @(posedge sys_clk) begin
    if (rx_valid) sh_q <= {sh_q[55:0], rx_byte};
    if (rst || rx_frame_end) n_q <= 8'h00;
    else if (tx_valid && tx_ready) n_q <= n_q + 8'h01;
    err_q <= !rst && !rx_frame_end && bad;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Six idle cycles cover the E+3 answer slot with margin
  sequence s_quiet;
    !tx_valid [*6];
  endsequence
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
  endproperty
  property p_take;
    tx_valid && tx_ready |=> !tx_valid;
  endproperty
  property p_foreign;
    rx_frame_end && sh_q[63:56] != own_addr && sh_q[63:56] != 8'h00
      |=> s_quiet;
  endproperty
  property p_bcast;
    rx_frame_end && sh_q[63:56] == 8'h00 |=> s_quiet;
  endproperty
  property p_err;
    rx_frame_end && bad |=> s_quiet;
  endproperty
  property p_addr;
    tx_valid && n_q == 8'h00 |-> tx_byte == own_addr;
  endproperty
  property p_func;
    tx_valid && n_q == 8'h01 |-> tx_byte[6:0] == sh_q[54:48];
  endproperty
  property p_coil;
    $changed(drive_energise) |-> sh_q[55:32] == 24'h050000
      && drive_energise == (sh_q[31:16] == 16'hFF00);
  endproperty
  property p_mode;
    $changed(control_mode_param) |-> sh_q[55:32] == 24'h060064
      && control_mode_param == sh_q[31:16];
  endproperty
  a_hold: assert property (p_hold)
    else $error("tx byte moved before take");
  a_take: assert property (p_take)
    else $error("tx valid held after take");
  a_foreign: assert property (p_foreign)
    else $error("answer to foreign address");
  a_bcast: assert property (p_bcast)
    else $error("answer to broadcast");
  a_err: assert property (p_err)
    else $error("answer to faulty frame");
  a_addr: assert property (p_addr)
    else $error("reply address wrong");
  a_func: assert property (p_func)
    else $error("reply function wrong");
  a_coil: assert property (p_coil)
    else $error("coil changed wrongly");
  a_mode: assert property (p_mode)
    else $error("control mode changed wrongly");
endmodule
bind msfh_slave msfh_assertions u_chk (.sys_clk, .rst, .own_addr, .rx_byte,
  .rx_valid, .rx_frame_end, .rx_char_err, .rx_gap_err, .tx_ready, .tx_byte,
  .tx_valid, .drive_energise, .control_mode_param);
`default_nettype wire

// *** verif/msfh_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module msfh_master (
  input wire logic sys_clk,
  output logic [7:0] rx_byte = 8'h00,
  output logic rx_valid = 1'b0,
  output logic rx_frame_end = 1'b0,
  output logic rx_char_err = 1'b0,
  output logic rx_gap_err = 1'b0,
  output logic tx_ready = 1'b0,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid
);
  logic slow = 1'b0;
  logic [2:0] cyc = 3'h0;
  logic [7:0] rsp[$];
  always @(posedge sys_clk) begin
    cyc <= cyc + 3'h1;
    // Slow mode takes one byte in eight to stress the hold
    tx_ready <= !slow || cyc == 3'h0;
    if (tx_valid && tx_ready) rsp.push_back(tx_byte);
  end
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Bit 0 of e corrupts the CRC, bit 1 flags a short gap, bit 2 a bad char
  task automatic send(input logic [7:0] f[$], input int e);
    logic [15:0] c;
    c = crc(f) ^ {15'h0000, e[0]};
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    foreach (f[i]) begin
      @(posedge sys_clk);
      rx_byte <= f[i];
      rx_valid <= 1'b1;
      rx_gap_err <= e[1] && i == 3;
      rx_char_err <= e[2] && i == 5;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_gap_err <= 1'b0;
      rx_char_err <= 1'b0;
      // Idle data is not left at its last value
      rx_byte <= ~f[i];
    end
    @(posedge sys_clk);
    rx_frame_end <= 1'b1;
    @(posedge sys_clk);
    rx_frame_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_modbus_slave_function_handler.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb_modbus_slave_function_handler;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_byte, tx_byte, xr[$];
  logic rx_valid, rx_frame_end, rx_char_err, rx_gap_err, tx_ready, tx_valid;
  logic de;
  logic ce = 1'b1;
  logic [15:0] cm;
  int fails = 0;
  int compares = 0;
  int tn = 0;
  always #5 sys_clk = ~sys_clk;
  msfh_master m (.sys_clk, .rx_byte, .rx_valid, .rx_frame_end, .rx_char_err,
    .rx_gap_err, .tx_ready, .tx_byte, .tx_valid);
  msfh_slave dut (.sys_clk, .rst, .ce, .own_addr(8'h08), .rx_byte,
    .rx_valid, .rx_frame_end, .rx_char_err, .rx_gap_err, .tx_ready,
    .position_in(32'h00030D40), .tx_byte, .tx_valid, .drive_energise(de),
    .control_mode_param(cm));
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // k: FF echo, FE reply preset in xr, 00 silent, else exception code
  task automatic run(input logic [7:0] a, fc, input logic [15:0] w1, w2,
      input int e, input logic [7:0] k);
    logic [7:0] q[$];
    logic [15:0] c;
    q = '{a, fc, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
    if (k == 8'hFF) xr = q;
    else if (k != 8'hFE) xr = '{a, fc | 8'h80, k};
    if (k == 8'h00 || e != 0) xr.delete();
    if (xr.size() > 0) begin
      c = m.crc(xr);
      xr.push_back(c[15:8]);
      xr.push_back(c[7:0]);
    end
    m.rsp.delete();
    m.send(q, e);
    for (int i = 0; i < 300 && m.rsp.size() < xr.size(); i++)
      @(posedge sys_clk);
    repeat (30) @(posedge sys_clk);
    `CHK(m.rsp.size(), xr.size())
    foreach (xr[i]) if (i < m.rsp.size()) `CHK(m.rsp[i], xr[i])
    tn++;
    $display("test %0d done", tn);
  endtask
  // Broadcast address is only ever used with the two write functions
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    run(8'h08, 8'h08, 16'h0000, 16'h1234, 0, 8'hFF);
    m.slow = 1'b1;
    run(8'h08, 8'h08, 16'h0001, 16'h1234, 0, 8'h02);
    xr = '{8'h08, 8'h03, 8'h04, 8'h0D, 8'h40, 8'h00, 8'h03};
    run(8'h08, 8'h03, 16'h0026, 16'h0002, 0, 8'hFE);
    run(8'h08, 8'h03, 16'h0026, 16'h0000, 0, 8'h03);
    run(8'h08, 8'h03, 16'h0026, 16'h0031, 0, 8'h03);
    run(8'h08, 8'h03, 16'h0026, 16'h0030, 0, 8'h02);
    run(8'h08, 8'h06, 16'h0064, 16'h0001, 0, 8'hFF);
    `CHK(cm, 16'h0001)
    run(8'h08, 8'h05, 16'h0000, 16'hFF00, 0, 8'hFF);
    `CHK(de, 1'b1)
    run(8'h00, 8'h05, 16'h0000, 16'h0000, 0, 8'h00);
    `CHK(de, 1'b0)
    run(8'h00, 8'h06, 16'h0064, 16'h0005, 0, 8'h00);
    run(8'h08, 8'h06, 16'h0064, 16'h0009, 1, 8'hFF);
    run(8'h09, 8'h05, 16'h0000, 16'hFF00, 0, 8'h00);
    run(8'h08, 8'h05, 16'h0000, 16'hFF00, 2, 8'hFF);
    run(8'h08, 8'h06, 16'h0064, 16'h0007, 4, 8'hFF);
    // Frozen block must neither store nor answer
    ce <= 1'b0;
    run(8'h08, 8'h06, 16'h0064, 16'h0007, 0, 8'h00);
    ce <= 1'b1;
    run(8'h08, 8'h01, 16'h0000, 16'h0001, 0, 8'h01);
    run(8'h08, 8'h06, 16'h0026, 16'h0001, 0, 8'h22);
    run(8'h08, 8'h05, 16'h0000, 16'h1234, 0, 8'h03);
    run(8'h08, 8'h05, 16'h0001, 16'hFF00, 0, 8'h02);
    `CHK(de, 1'b0)
    `CHK(cm, 16'h0005)
    xr = '{8'h08, 8'h03, 8'h02, 8'h00, 8'h05};
    run(8'h08, 8'h03, 16'h0064, 16'h0001, 0, 8'hFE);
    xr = '{8'h08, 8'h03, 8'h02, 8'h00, 8'h03};
    run(8'h08, 8'h03, 16'h0027, 16'h0001, 0, 8'hFE);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
